// file: shared/port_a_pkg.sv
// Shared constants, register map and carrier types of the port A block.
package port_a_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_PIN_DATA = 8'h00;
	localparam logic [7:0] OFS_DIRECTION = 8'h04;
	localparam logic [7:0] OFS_ANALOG_SELECT = 8'h08;
	localparam logic [7:0] OFS_PIN_STEERING = 8'h0c;
	localparam logic [7:0] OFS_BIT_MODIFY = 8'h10;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_DIRECTION = 8'hff;
	localparam logic [7:0] RST_ANALOG_SELECT = 8'h3f;
	localparam logic [7:0] RST_PIN_STEERING = 8'h00;
	localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;

	// ----------------------------------------------------------------
	// Field positions and masks
	// ----------------------------------------------------------------
	localparam int SS_CHOICE_BIT = 1;
	localparam int CAPCOMP2_CHOICE_BIT = 0;
	localparam logic [7:0] STEERING_MASK = 8'h03;
	localparam int SS_PRIMARY_PIN = 5;
	localparam int SS_ALT_PIN = 0;
	localparam int TIMER0_PIN = 4;
	localparam int MODIFY_MASK_LSB = 8;

	// ----------------------------------------------------------------
	// Bus encodings
	// ----------------------------------------------------------------
	localparam logic [2:0] HSIZE_WORD = 3'b010;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [2:0] {
		REG_NONE = 3'b000,
		REG_DATA = 3'b001,
		REG_DIR = 3'b010,
		REG_ANALOG = 3'b011,
		REG_STEER = 3'b100,
		REG_MODIFY = 3'b101
	} reg_sel_e;

	typedef struct packed {
		logic active;
		logic write;
		reg_sel_e sel;
	} bus_phase_s;

	typedef struct packed {
		logic unit_in;
		logic primary_out;
		logic primary_oe_n;
		logic alt_out;
		logic alt_oe_n;
	} route_s;

endpackage

// file: logic/two_pin_route.sv
// Steers one peripheral function between a primary and an alternate pin.
module two_pin_route (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_choose_alt,
	input wire logic i_primary_in,
	input wire logic i_alt_in,
	input wire logic i_unit_drive,
	input wire logic i_unit_out,
	output logic o_unit_in,
	output logic o_primary_out,
	output logic o_primary_oe_n,
	output logic o_alt_out,
	output logic o_alt_oe_n
);

	port_a_pkg::route_s route_reg;
	port_a_pkg::route_s route_next;

	// ----------------------------------------------------------------
	// Selection
	// ----------------------------------------------------------------
	// The unselected pin is always released so two pins never fight.
	always_comb begin
		route_next.unit_in = i_choose_alt ? i_alt_in : i_primary_in;
		route_next.primary_out = i_unit_out;
		route_next.primary_oe_n = !(i_unit_drive && !i_choose_alt);
		route_next.alt_out = i_unit_out;
		route_next.alt_oe_n = !(i_unit_drive && i_choose_alt);
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			route_reg <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
		end else begin
			route_reg <= route_next;
		end
	end

	assign o_unit_in = route_reg.unit_in;
	assign o_primary_out = route_reg.primary_out;
	assign o_primary_oe_n = route_reg.primary_oe_n;
	assign o_alt_out = route_reg.alt_out;
	assign o_alt_oe_n = route_reg.alt_oe_n;

endmodule

// file: logic/port_a_gpio.sv
// Eight-bit general purpose port A with analog select and pin steering.
// What this block does
// - Steering bit 1 takes slave select from pin 5 when 0, pin 0 when 1.
// - Steering bit 0 puts capture/compare unit 2 on C1 when 0, B3 when 1.
// - Eight pins, each bidirectional under its own direction bit.
// - Direction bit 1 makes the pin an input with its driver off.
// - Direction bit 0 drives the pin with its output latch bit.
// - Data reads return pin levels; data writes load the output latch.
// - Every bit modify write with a nonzero mask samples pins, modifies, then stores into the latch.
// - Direction bits keep driver control while a pin is analog.
// - Analog pins always read 0 on a digital data read.
// - Analog bits 5..0 disable the digital input buffer of that pin.
// - Analog select changes output drive only through bit modify, which stores 0 for an analog pin outside the mask.
// - Analog select bits 7 and 6 are absent and read 0.
// - Timer 0 clock comes from the gated pin 4 view: the pin level whatever its direction, 0 while pin 4 is analog.
module port_a_gpio #(
	parameter int ANALOG_WIDTH = 6
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic [7:0] i_port_a_pin,
	output logic [7:0] o_port_a_pin,
	output logic [7:0] o_port_a_pin_oe_n,
	output logic o_timer0_external_clock_in,
	output logic o_sync_serial_unit_select,
	input wire logic i_capcomp_unit2_signal,
	input wire logic i_capcomp_unit2_drive,
	output logic o_capcomp_unit2_signal,
	input wire logic i_port_c_pin1,
	output logic o_port_c_pin1,
	output logic o_port_c_pin1_oe_n,
	input wire logic i_port_b_pin3,
	output logic o_port_b_pin3,
	output logic o_port_b_pin3_oe_n
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (ANALOG_WIDTH < 1 || ANALOG_WIDTH > 8) begin : g_bad_width
		$error("ANALOG_WIDTH must lie between 1 and 8");
	end

	localparam logic [7:0] ANALOG_MASK =
		8'((9'h001 << ANALOG_WIDTH) - 9'h001);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] dir_reg, dir_next;
	logic [7:0] latch_reg, latch_next;
	logic [7:0] analog_reg, analog_next;
	logic [7:0] steer_reg, steer_next;
	logic [7:0] sample_reg;
	logic [31:0] rdata_reg, rdata_next;
	logic timer0_reg, ready_reg, resp_reg;
	port_a_pkg::bus_phase_s phase_reg, phase_next;
	port_a_pkg::reg_sel_e addr_sel;
	logic take_addr, data_write;
	logic [7:0] pin_view;
	logic [7:0] wr_mask, wr_value;

	// ----------------------------------------------------------------
	// Digital input view
	// ----------------------------------------------------------------
	// buffer gating
	assign pin_view = sample_reg & ~(analog_reg & ANALOG_MASK);

	// ----------------------------------------------------------------
	// Address phase decode
	// ----------------------------------------------------------------
	assign take_addr = i_hsel && i_hready && i_htrans[1];

	always_comb begin
		if (i_haddr[31:8] != 24'h000000) begin
			addr_sel = port_a_pkg::REG_NONE;
		end else if (i_haddr[7:0] == port_a_pkg::OFS_PIN_DATA) begin
			addr_sel = port_a_pkg::REG_DATA;
		end else if (i_haddr[7:0] == port_a_pkg::OFS_DIRECTION) begin
			addr_sel = port_a_pkg::REG_DIR;
		end else if (i_haddr[7:0] == port_a_pkg::OFS_ANALOG_SELECT) begin
			addr_sel = port_a_pkg::REG_ANALOG;
		end else if (i_haddr[7:0] == port_a_pkg::OFS_PIN_STEERING) begin
			addr_sel = port_a_pkg::REG_STEER;
		end else if (i_haddr[7:0] == port_a_pkg::OFS_BIT_MODIFY) begin
			addr_sel = port_a_pkg::REG_MODIFY;
		end else begin
			addr_sel = port_a_pkg::REG_NONE;
		end
	end

	// Writes narrower than a word are dropped rather than half applied.
	always_comb begin
		phase_next.active = take_addr;
		phase_next.write = take_addr && i_hwrite &&
			(i_hsize == port_a_pkg::HSIZE_WORD);
		phase_next.sel = take_addr ? addr_sel : port_a_pkg::REG_NONE;
	end

	// ----------------------------------------------------------------
	// Register writes in the data phase
	// ----------------------------------------------------------------
	assign data_write = phase_reg.active && phase_reg.write;

	always_comb begin
		dir_next = dir_reg;
		latch_next = latch_reg;
		analog_next = analog_reg;
		steer_next = steer_reg;
		wr_mask = 8'h00;
		wr_value = 8'h00;
		if (data_write) begin
			if (phase_reg.sel == port_a_pkg::REG_DATA) begin
				wr_mask = 8'hff;
				wr_value = i_hwdata[7:0];
			end else if (phase_reg.sel == port_a_pkg::REG_MODIFY) begin
				wr_mask = i_hwdata[port_a_pkg::MODIFY_MASK_LSB +: 8];
				wr_value = i_hwdata[7:0];
			end else if (phase_reg.sel == port_a_pkg::REG_DIR) begin
				dir_next = i_hwdata[7:0];
			end else if (phase_reg.sel == port_a_pkg::REG_ANALOG) begin
				analog_next = i_hwdata[7:0] & ANALOG_MASK;
			end else if (phase_reg.sel == port_a_pkg::REG_STEER) begin
				steer_next = i_hwdata[7:0] & port_a_pkg::STEERING_MASK;
			end
			// sample, modify, store
			// Bits left out of the mask take the pin view, so an analog
			// pin driven high comes back as a zero in the latch.
			if (wr_mask != 8'h00) begin
				latch_next = (pin_view & ~wr_mask) | (wr_value & wr_mask);
			end
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Read data other than pin data is taken from the next values so that a read
	// straight after a write returns the freshly written register.
	always_comb begin
		rdata_next = 32'h00000000;
		if (take_addr && !i_hwrite) begin
			if (addr_sel == port_a_pkg::REG_DATA) begin
				rdata_next = {24'h000000, pin_view};
			end else if (addr_sel == port_a_pkg::REG_DIR) begin
				rdata_next = {24'h000000, dir_next};
			end else if (addr_sel == port_a_pkg::REG_ANALOG) begin
				rdata_next = {24'h000000, analog_next & ANALOG_MASK};
			end else if (addr_sel == port_a_pkg::REG_STEER) begin
				rdata_next = {24'h000000, steer_next};
			end else if (addr_sel == port_a_pkg::REG_MODIFY) begin
				rdata_next = {24'h000000, latch_next};
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// write edge, pin sampling
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			dir_reg <= port_a_pkg::RST_DIRECTION;
			latch_reg <= port_a_pkg::RST_OUTPUT_LATCH;
			analog_reg <= port_a_pkg::RST_ANALOG_SELECT;
			steer_reg <= port_a_pkg::RST_PIN_STEERING;
			sample_reg <= 8'h00;
			rdata_reg <= 32'h00000000;
			phase_reg <= '{1'b0, 1'b0, port_a_pkg::REG_NONE};
			timer0_reg <= 1'b0;
			ready_reg <= 1'b1;
			resp_reg <= port_a_pkg::HRESP_OKAY;
		end else begin
			dir_reg <= dir_next;
			latch_reg <= latch_next;
			analog_reg <= analog_next;
			steer_reg <= steer_next;
			sample_reg <= i_port_a_pin;
			rdata_reg <= rdata_next;
			phase_reg <= phase_next;
			timer0_reg <= pin_view[port_a_pkg::TIMER0_PIN];
			ready_reg <= 1'b1;
			resp_reg <= port_a_pkg::HRESP_OKAY;
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	// latch onto pins
	assign o_port_a_pin = latch_reg;
	assign o_port_a_pin_oe_n = dir_reg;

	assign o_hrdata = rdata_reg;
	assign o_hreadyout = ready_reg;
	assign o_hresp = resp_reg;
	assign o_timer0_external_clock_in = timer0_reg;

	// ----------------------------------------------------------------
	// Peripheral pin steering
	// ----------------------------------------------------------------
	// slave select source
	two_pin_route u_ss_route (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_choose_alt(steer_reg[port_a_pkg::SS_CHOICE_BIT]),
		.i_primary_in(pin_view[port_a_pkg::SS_PRIMARY_PIN]),
		.i_alt_in(pin_view[port_a_pkg::SS_ALT_PIN]),
		.i_unit_drive(1'b0),
		.i_unit_out(1'b0),
		.o_unit_in(o_sync_serial_unit_select),
		.o_primary_out(),
		.o_primary_oe_n(),
		.o_alt_out(),
		.o_alt_oe_n()
	);

	two_pin_route u_capcomp2_route (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_choose_alt(steer_reg[port_a_pkg::CAPCOMP2_CHOICE_BIT]),
		.i_primary_in(i_port_c_pin1),
		.i_alt_in(i_port_b_pin3),
		.i_unit_drive(i_capcomp_unit2_drive),
		.i_unit_out(i_capcomp_unit2_signal),
		.o_unit_in(o_capcomp_unit2_signal),
		.o_primary_out(o_port_c_pin1),
		.o_primary_oe_n(o_port_c_pin1_oe_n),
		.o_alt_out(o_port_b_pin3),
		.o_alt_oe_n(o_port_b_pin3_oe_n)
	);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic dir_wr, data_wr, modify_wr, data_rd, analog_rd;
	assign dir_wr = data_write && phase_reg.sel == port_a_pkg::REG_DIR;
	assign data_wr = data_write && phase_reg.sel == port_a_pkg::REG_DATA;
	assign modify_wr = data_write && phase_reg.sel == port_a_pkg::REG_MODIFY;
	assign data_rd = take_addr && !i_hwrite &&
		addr_sel == port_a_pkg::REG_DATA;
	assign analog_rd = take_addr && !i_hwrite &&
		addr_sel == port_a_pkg::REG_ANALOG;
	property p_dir_drive;
		@(posedge i_clk) disable iff (!i_resetn)
		dir_wr |=> o_port_a_pin_oe_n == $past(i_hwdata[7:0]);
	endproperty
	a_dir_drive: assert property (p_dir_drive)
		else $error("driver enables do not follow direction write");
	property p_dir_hold;
		@(posedge i_clk) disable iff (!i_resetn)
		!dir_wr |=> $stable(o_port_a_pin_oe_n);
	endproperty
	a_dir_hold: assert property (p_dir_hold)
		else $error("driver enables changed without direction write");
	property p_latch_write;
		@(posedge i_clk) disable iff (!i_resetn)
		data_wr |=> o_port_a_pin == $past(i_hwdata[7:0]);
	endproperty
	a_latch_write: assert property (p_latch_write)
		else $error("pin drive differs from written latch value");
	property p_modify;
		@(posedge i_clk) disable iff (!i_resetn)
		modify_wr |=> o_port_a_pin ==
			(($past(pin_view) & ~$past(i_hwdata[15:8])) |
			($past(i_hwdata[7:0]) & $past(i_hwdata[15:8])));
	endproperty
	a_modify: assert property (p_modify)
		else $error("bit modify did not merge sampled pins");
	property p_read_pins;
		@(posedge i_clk) disable iff (!i_resetn)
		data_rd |=> o_hrdata == {24'h000000, $past(pin_view)};
	endproperty
	a_read_pins: assert property (p_read_pins)
		else $error("data read does not return sampled pins");
	property p_analog_zero;
		@(posedge i_clk) disable iff (!i_resetn)
		data_rd |=> (o_hrdata[7:0] & $past(analog_reg)) == 8'h00;
	endproperty
	a_analog_zero: assert property (p_analog_zero)
		else $error("analog pin read back as one");
	property p_analog_upper;
		@(posedge i_clk) disable iff (!i_resetn)
		analog_rd |=> o_hrdata[31:ANALOG_WIDTH] == '0;
	endproperty
	a_analog_upper: assert property (p_analog_upper)
		else $error("absent analog select bits read as one");
	property p_ss_route;
		@(posedge i_clk) disable iff (!i_resetn)
		##1 o_sync_serial_unit_select ==
			($past(steer_reg[1]) ? $past(pin_view[0]) : $past(pin_view[5]));
	endproperty
	a_ss_route: assert property (p_ss_route)
		else $error("slave select taken from the wrong pin");
	property p_cc2_route;
		@(posedge i_clk) disable iff (!i_resetn)
		steer_reg[0] |=> o_port_c_pin1_oe_n &&
			o_port_b_pin3_oe_n == !$past(i_capcomp_unit2_drive);
	endproperty
	a_cc2_route: assert property (p_cc2_route)
		else $error("unit 2 drive not on the selected pin");
	property p_timer0;
		@(posedge i_clk) disable iff (!i_resetn)
		##1 o_timer0_external_clock_in == $past(pin_view[4]);
	endproperty
	a_timer0: assert property (p_timer0)
		else $error("timer 0 clock does not follow pin 4");
	property p_ready;
		@(posedge i_clk) disable iff (!i_resetn)
		take_addr |=> o_hreadyout && o_hresp == 1'b0;
	endproperty
	a_ready: assert property (p_ready)
		else $error("bus answer was not a zero wait OKAY");

endmodule

// file: sim/pad_model.sv
// Pad ring model for port A and the two capture/compare unit 2 pads.
module pad_model (
	input wire logic [7:0] i_drive,
	input wire logic [7:0] i_drive_oe_n,
	input wire logic [7:0] i_ext,
	input wire logic [7:0] i_ext_en,
	input wire logic i_c1_drive,
	input wire logic i_c1_oe_n,
	input wire logic i_c1_ext,
	input wire logic i_b3_drive,
	input wire logic i_b3_oe_n,
	input wire logic i_b3_ext,
	output logic [7:0] o_pad,
	output logic o_c1_pad,
	output logic o_b3_pad
);
	timeunit 1ns;
	timeprecision 1ps;

	// pad level resolution
	// An undriven port A pad with no external drive floats high through the
	// board pull-up, so a released pin never keeps showing the last driven value.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (i_drive_oe_n[i] == 1'b0) begin
				o_pad[i] = i_drive[i];
			end else if (i_ext_en[i]) begin
				o_pad[i] = i_ext[i];
			end else begin
				o_pad[i] = 1'b1;
			end
		end
		o_c1_pad = (i_c1_oe_n == 1'b0) ? i_c1_drive : i_c1_ext;
		o_b3_pad = (i_b3_oe_n == 1'b0) ? i_b3_drive : i_b3_ext;
	end
endmodule

// file: sim/tb.sv
// Self-checking bench for the port A block.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk, i_resetn, hsel, hwrite, cc_sig, cc_drv, c1_ext, b3_ext;
	logic [1:0] htrans;
	logic [2:0] hsize, sz;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic hready, hresp, t0, ss, cc_in, c1_out, c1_oe_n, b3_out, b3_oe_n;
	logic c1_pad, b3_pad;
	logic [7:0] pad, pout, poe_n, ext_v, ext_en, dir, ana, lat, st, m, vw;
	int err_total, cmp_count;
	int cyc = 0;

	port_a_gpio #(.ANALOG_WIDTH(6)) DUT (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_port_a_pin(pad), .o_port_a_pin(pout), .o_port_a_pin_oe_n(poe_n),
		.o_timer0_external_clock_in(t0), .o_sync_serial_unit_select(ss),
		.i_capcomp_unit2_signal(cc_sig), .i_capcomp_unit2_drive(cc_drv),
		.o_capcomp_unit2_signal(cc_in), .i_port_c_pin1(c1_pad),
		.o_port_c_pin1(c1_out), .o_port_c_pin1_oe_n(c1_oe_n),
		.i_port_b_pin3(b3_pad), .o_port_b_pin3(b3_out),
		.o_port_b_pin3_oe_n(b3_oe_n)
	);

	pad_model u_pads (
		.i_drive(pout), .i_drive_oe_n(poe_n), .i_ext(ext_v),
		.i_ext_en(ext_en), .i_c1_drive(c1_out), .i_c1_oe_n(c1_oe_n),
		.i_c1_ext(c1_ext), .i_b3_drive(b3_out), .i_b3_oe_n(b3_oe_n),
		.i_b3_ext(b3_ext), .o_pad(pad), .o_c1_pad(c1_pad),
		.o_b3_pad(b3_pad)
	);

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// ----------------------------------------------------------------
	// Expectations and bus cycles
	// ----------------------------------------------------------------
	function automatic logic [7:0] pad_f(logic [7:0] d, logic [7:0] l,
		logic [7:0] e, logic [7:0] en);
		return (~d & l) | (d & en & e) | (d & ~en);
	endfunction

	// Analog pins read low whatever the pad does.
	function automatic logic [7:0] view_f(logic [7:0] p, logic [7:0] a);
		return p & ~(a & 8'h3f);
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge i_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		hsize <= sz;
		do @(posedge i_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge i_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus(1'b0, a, 32'h00000000, d);
	endtask

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// A hung handshake ends the run here rather than never.
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 8000) begin
			err_total++;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rdv = $urandom(47137);
		err_total = 0;
		cmp_count = 0;
		i_resetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h00000000;
		hwrite = 1'b0;
		sz = port_a_pkg::HSIZE_WORD;
		hsize = sz;
		hwdata = 32'h00000000;
		ext_v = 8'h00;
		ext_en = 8'h00;
		{cc_sig, cc_drv, c1_ext, b3_ext} = 4'h0;
		repeat (6) @(posedge i_clk);
		i_resetn <= 1'b1;
		rd(port_a_pkg::OFS_DIRECTION, rdv); chk(rdv, 32'h000000ff);
		rd(port_a_pkg::OFS_ANALOG_SELECT, rdv); chk(rdv, 32'h3f);
		rd(port_a_pkg::OFS_PIN_STEERING, rdv); chk(rdv, 32'h0);
		rd(port_a_pkg::OFS_PIN_DATA, rdv); chk(rdv, 32'hc0);
		rd(8'h14, rdv); chk(rdv, 32'h0);
		chk(poe_n, 8'hff);
		chk(pout, port_a_pkg::RST_OUTPUT_LATCH);
		wr(port_a_pkg::OFS_ANALOG_SELECT, 32'hff);
		rd(port_a_pkg::OFS_ANALOG_SELECT, rdv); chk(rdv, 32'h3f);
		sz = 3'b000;
		wr(port_a_pkg::OFS_DIRECTION, 32'h0);
		sz = port_a_pkg::HSIZE_WORD;
		rd(port_a_pkg::OFS_DIRECTION, rdv); chk(rdv, 32'hff);
		// Analog pin left as output on purpose: it drives, reads low.
		wr(port_a_pkg::OFS_ANALOG_SELECT, 32'h01);
		wr(port_a_pkg::OFS_DIRECTION, 32'hfe);
		wr(port_a_pkg::OFS_PIN_DATA, 32'hff);
		@(posedge i_clk); chk(pout, 8'hff);
		chk(poe_n, 8'hfe);
		repeat (3) @(posedge i_clk);
		rd(port_a_pkg::OFS_PIN_DATA, rdv); chk(rdv, 32'hfe);
		wr(port_a_pkg::OFS_BIT_MODIFY, 32'h0202);
		repeat (2) @(posedge i_clk); chk(pout, 8'hfe);
		for (int k = 0; k < 24; k++) begin
			dir = 8'($urandom);
			ana = 8'($urandom);
			lat = 8'($urandom);
			st = 8'($urandom);
			dir = dir | (ana & 8'h3f);
			@(posedge i_clk);
			ext_v <= 8'($urandom);
			ext_en <= 8'($urandom) & dir;
			{cc_sig, cc_drv, c1_ext, b3_ext} <= 4'($urandom);
			wr(port_a_pkg::OFS_DIRECTION, {24'h0, dir});
			wr(port_a_pkg::OFS_ANALOG_SELECT, {24'h0, ana});
			wr(port_a_pkg::OFS_PIN_DATA, {24'h0, lat});
			wr(port_a_pkg::OFS_PIN_STEERING, {24'h0, st});
			repeat (3) @(posedge i_clk);
			vw = view_f(pad_f(dir, lat, ext_v, ext_en), ana);
			rd(port_a_pkg::OFS_PIN_DATA, rdv); chk(rdv, {24'h0, vw});
			rd(port_a_pkg::OFS_PIN_STEERING, rdv); chk(rdv, st & 8'h03);
			chk(poe_n, dir);
			chk(pout, lat);
			chk(t0, vw[4]);
			chk(ss, st[1] ? vw[0] : vw[5]);
			chk(c1_oe_n, !(cc_drv && !st[0]));
			chk(b3_oe_n, !(cc_drv && st[0]));
			chk(c1_out, cc_sig);
			chk(b3_out, cc_sig);
			chk(hresp, port_a_pkg::HRESP_OKAY);
			chk(cc_in, cc_drv ? cc_sig : (st[0] ? b3_ext : c1_ext));
			m = 8'($urandom);
			wr(port_a_pkg::OFS_BIT_MODIFY, {16'h0, m, ~lat});
			repeat (2) @(posedge i_clk);
			chk(pout, (vw & ~m) | (~lat & m));
			rd(port_a_pkg::OFS_BIT_MODIFY, rdv);
			chk(rdv, {24'h0, (vw & ~m) | (~lat & m)});
		end
		conclude();
	end
endmodule
